// >>> core/msps_params.svh
// Constants of the multi-speed preset selector: offsets, field codes, reset values.
// Assumes inclusion by bare name from the core files; frequencies are in 0.1 Hz steps.
//
// Behaviour
// - Fifteen programmable presets, chosen only by the four speed select inputs.
// - High, middle, low select alone pick their presets; reset 50, 30, 10 Hz.
// - Presets four to fifteen take 0-400 Hz or not-selected; reset to not-selected.
// - Speed eight not-selected with only extension on gives the low preset.
// - Several of high, middle, low on, their combination preset not-selected: lowest signal wins, middle beats high.
// - Source ranking: jog, presets, voltage-current analog, then voltage analog.
// - Preset selection only in external or combined operation mode, codes 3 or 4.
// - Nonzero remote function makes selects remote signals and disables presets.
// - Preset writes accepted while running, any mode, whatever the write protection.
// - Terminal assignment codes 0, 1, 2 route low, middle, high select.
// - Extension select has no default terminal; it comes from code 8.
// - Presets four to fifteen writable only while user group read selection is zero.
`ifndef MSPS_PARAMS_SVH
`define MSPS_PARAMS_SVH

`define MSPS_FREQ_W      16
`define MSPS_NUM_PRESET  15
`define MSPS_NUM_TERM    7
`define MSPS_ADDR_W      12

`define MSPS_NOT_SEL     16'h270F
`define MSPS_FREQ_MAX    16'h0FA0
`define MSPS_HIGH_RST    16'h01F4
`define MSPS_MID_RST     16'h012C
`define MSPS_LOW_RST     16'h0064

`define MSPS_SLOT_HIGH   4'h0
`define MSPS_SLOT_MID    4'h1
`define MSPS_SLOT_LOW    4'h2
`define MSPS_SLOT_SPD4   4'h3
`define MSPS_SLOT_SPD8   4'h7

`define MSPS_FN_LOW      8'h00
`define MSPS_FN_MID      8'h01
`define MSPS_FN_HIGH     8'h02
`define MSPS_FN_EXT      8'h08
`define MSPS_FN_NONE     8'hFF

`define MSPS_MODE_EXT    4'h3
`define MSPS_MODE_COMB   4'h4
`define MSPS_MODE_RST    4'h0

`define MSPS_WR_STOP     2'h0
`define MSPS_WR_OFF      2'h1

`define MSPS_OFF_OPMODE  12'h000
`define MSPS_OFF_REMOTE  12'h004
`define MSPS_OFF_WRSEL   12'h008
`define MSPS_OFF_UGRP    12'h00C
`define MSPS_OFF_STATUS  12'h010
`define MSPS_OFF_INPUTS  12'h014
`define MSPS_OFF_TERM    12'h020
`define MSPS_OFF_PRESET  12'h040

`endif

// >>> core/msps_pkg.sv
// Types shared by the multi-speed preset selector files.
// Assumes msps_params.svh is on the include path.
`include "msps_params.svh"

package msps_pkg;

  typedef logic [`MSPS_FREQ_W-1:0] msps_freq_t;
  typedef logic [3:0]              msps_slot_t;

  typedef enum logic [1:0] {
    MSPS_SRC_JOG,
    MSPS_SRC_PRESET,
    MSPS_SRC_ANALOG4,
    MSPS_SRC_ANALOG2
  } msps_src_e;

endpackage

// >>> core/msps_decode.sv
// Combination decoder from the four speed select signals to a preset slot.
// Assumes synchronised select signals and the stored preset table.
`timescale 1ns/1ps
`include "msps_params.svh"

module msps_decode (
  input  wire logic                high_speed_select,
  input  wire logic                middle_speed_select,
  input  wire logic                low_speed_select,
  input  wire logic                speed_extension_select,
  input  msps_pkg::msps_freq_t     preset [`MSPS_NUM_PRESET],
  output logic                     hit,
  output msps_pkg::msps_slot_t     slot,
  output msps_pkg::msps_freq_t     freq
);
  import msps_pkg::*;

  logic [2:0] sel3;
  msps_slot_t base_slot;
  msps_slot_t combo_slot;
  msps_slot_t ext_slot;
  logic       base_hit;
  logic       combo_hit;

  assign sel3 = {high_speed_select, middle_speed_select, low_speed_select};

  always_comb begin
    base_hit   = 1'b1;
    base_slot  = `MSPS_SLOT_LOW;
    combo_hit  = 1'b1;
    combo_slot = `MSPS_SLOT_SPD4;
    // Lowest signal wins when combinations are not set
    if (low_speed_select) begin
      base_slot = `MSPS_SLOT_LOW;
    end else if (middle_speed_select) begin
      base_slot = `MSPS_SLOT_MID;
    end else if (high_speed_select) begin
      base_slot = `MSPS_SLOT_HIGH;
    end else begin
      base_hit = 1'b0;
    end
    // Speeds four to seven
    case (sel3)
      3'b011:  combo_slot = `MSPS_SLOT_SPD4;
      3'b101:  combo_slot = `MSPS_SLOT_SPD4 + 4'h1;
      3'b110:  combo_slot = `MSPS_SLOT_SPD4 + 4'h2;
      3'b111:  combo_slot = `MSPS_SLOT_SPD4 + 4'h3;
      default: combo_hit  = 1'b0;
    endcase
    if (combo_hit && (preset[combo_slot] != `MSPS_NOT_SEL)) begin
      base_slot = combo_slot;
    end
    // Speeds eight to fifteen
    ext_slot = `MSPS_SLOT_SPD8 + {1'b0, sel3};
    hit      = base_hit;
    slot     = base_slot;
    if (speed_extension_select) begin
      if (preset[ext_slot] != `MSPS_NOT_SEL) begin
        hit  = 1'b1;
        slot = ext_slot;
      end else if (sel3 == 3'b000) begin
        hit  = 1'b1;
        slot = `MSPS_SLOT_LOW;
      end
    end
    freq = preset[slot];
  end

endmodule // msps_decode

// >>> core/msps_top.sv
// Multi-speed preset selector with APB parameter access and frequency command ranking.
// Assumes terminals are asynchronous pins; jog, analog and run status are pclk-domain logic.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "msps_params.svh"

module msps_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`MSPS_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [`MSPS_NUM_TERM-1:0]    term_in,
  input  wire logic                         running,
  input  wire logic                         jog_active,
  input  msps_pkg::msps_freq_t              jog_freq,
  input  wire logic                         analog4_valid,
  input  msps_pkg::msps_freq_t              analog4_freq,
  input  msps_pkg::msps_freq_t              analog2_freq,
  output msps_pkg::msps_freq_t              freq_cmd,
  output msps_pkg::msps_src_e               freq_src,
  output logic                              remote_accel,
  output logic                              remote_decel,
  output logic                              remote_clear
);
  import msps_pkg::*;

  // ==========================================================================
  // Terminal synchroniser
  // ==========================================================================
  logic [`MSPS_NUM_TERM-1:0] term_meta_q;
  logic [`MSPS_NUM_TERM-1:0] term_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_meta_q <= '0;
      term_sync_q <= '0;
    end else begin
      term_meta_q <= term_in;
      term_sync_q <= term_meta_q;
    end
  end

  // ==========================================================================
  // Parameter storage
  // ==========================================================================
  logic [3:0]  opmode_q;
  logic [3:0]  opmode_d;
  logic [3:0]  remote_q;
  logic [3:0]  remote_d;
  logic [1:0]  wrsel_q;
  logic [1:0]  wrsel_d;
  logic [15:0] ugrp_q;
  logic [15:0] ugrp_d;
  logic [7:0]  term_fn_q  [`MSPS_NUM_TERM];
  logic [7:0]  term_fn_d  [`MSPS_NUM_TERM];
  msps_freq_t  preset_q   [`MSPS_NUM_PRESET];
  msps_freq_t  preset_d   [`MSPS_NUM_PRESET];

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic [`MSPS_ADDR_W-1:0] term_off;
  logic [`MSPS_ADDR_W-1:0] preset_off;
  logic                    term_hit;
  logic                    preset_hit;
  logic [2:0]              term_idx;
  msps_slot_t              preset_idx;
  logic                    cfg_wr_ok;
  logic                    preset_wr_ok;
  logic                    range_ok;
  logic                    setup;
  logic                    access;
  logic [31:0]             rdata_d;
  logic                    err_d;
  logic                    pready_d;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;

  assign setup      = psel && !penable && !pready_q;
  assign access     = psel && penable && pready_q;
  assign term_off   = paddr - `MSPS_OFF_TERM;
  assign preset_off = paddr - `MSPS_OFF_PRESET;
  assign term_hit   = (paddr >= `MSPS_OFF_TERM) && (paddr[1:0] == 2'b00)
                      && (term_off[`MSPS_ADDR_W-1:2] < 10'(`MSPS_NUM_TERM));
  assign preset_hit = (paddr >= `MSPS_OFF_PRESET) && (paddr[1:0] == 2'b00)
                      && (preset_off[`MSPS_ADDR_W-1:2] < 10'(`MSPS_NUM_PRESET));
  assign term_idx   = term_off[4:2];
  assign preset_idx = preset_off[5:2];

  // Configuration follows the write protection; presets ignore it but check range and, from preset four on, user group
  assign cfg_wr_ok    = (wrsel_q != `MSPS_WR_OFF) && !(running && (wrsel_q == `MSPS_WR_STOP));
  assign range_ok     = (pwdata[31:16] == 16'h0000)
                        && ((pwdata[15:0] <= `MSPS_FREQ_MAX)
                        || ((preset_idx >= `MSPS_SLOT_SPD4) && (pwdata[15:0] == `MSPS_NOT_SEL)));
  assign preset_wr_ok = range_ok
                        && ((preset_idx < `MSPS_SLOT_SPD4) || (ugrp_q == 16'h0000));

  // ==========================================================================
  // Selection path
  // ==========================================================================
  logic       sel_high;
  logic       sel_mid;
  logic       sel_low;
  logic       sel_ext;
  logic [`MSPS_NUM_TERM-1:0] is_high;
  logic [`MSPS_NUM_TERM-1:0] is_mid;
  logic [`MSPS_NUM_TERM-1:0] is_low;
  logic [`MSPS_NUM_TERM-1:0] is_ext;
  logic       dec_hit;
  msps_slot_t dec_slot;
  msps_freq_t dec_freq;
  logic       mode_ok;
  logic       remote_on;

  genvar g;
  generate
    for (g = 0; g < `MSPS_NUM_TERM; g++) begin : g_term
      assign is_low[g]  = term_sync_q[g] && (term_fn_q[g] == `MSPS_FN_LOW);
      assign is_mid[g]  = term_sync_q[g] && (term_fn_q[g] == `MSPS_FN_MID);
      assign is_high[g] = term_sync_q[g] && (term_fn_q[g] == `MSPS_FN_HIGH);
      assign is_ext[g]  = term_sync_q[g] && (term_fn_q[g] == `MSPS_FN_EXT);
    end
  endgenerate

  assign sel_low   = |is_low;
  assign sel_mid   = |is_mid;
  assign sel_high  = |is_high;
  assign sel_ext   = |is_ext;
  assign mode_ok   = (opmode_q == `MSPS_MODE_EXT) || (opmode_q == `MSPS_MODE_COMB);
  assign remote_on = (remote_q != 4'h0);

  msps_decode u_decode (
    .high_speed_select      (sel_high),
    .middle_speed_select    (sel_mid),
    .low_speed_select       (sel_low),
    .speed_extension_select (sel_ext),
    .preset                 (preset_q),
    .hit                    (dec_hit),
    .slot                   (dec_slot),
    .freq                   (dec_freq)
  );

  // ==========================================================================
  // Command ranking
  // ==========================================================================
  msps_freq_t freq_d;
  msps_freq_t freq_q;
  msps_src_e  src_d;
  msps_src_e  src_q;
  logic [2:0] remote_sig_d;
  logic [2:0] remote_sig_q;

  always_comb begin
    if (jog_active) begin
      freq_d = jog_freq;
      src_d  = MSPS_SRC_JOG;
    end else if (mode_ok && !remote_on && dec_hit) begin
      freq_d = dec_freq;
      src_d  = MSPS_SRC_PRESET;
    end else if (analog4_valid) begin
      freq_d = analog4_freq;
      src_d  = MSPS_SRC_ANALOG4;
    end else begin
      freq_d = analog2_freq;
      src_d  = MSPS_SRC_ANALOG2;
    end
    remote_sig_d = remote_on ? {sel_high, sel_mid, sel_low} : 3'b000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q       <= '0;
      src_q        <= MSPS_SRC_ANALOG2;
      remote_sig_q <= 3'b000;
    end else begin
      freq_q       <= freq_d;
      src_q        <= src_d;
      remote_sig_q <= remote_sig_d;
    end
  end

  // ==========================================================================
  // Register next state
  // ==========================================================================
  always_comb begin
    opmode_d  = opmode_q;
    remote_d  = remote_q;
    wrsel_d   = wrsel_q;
    ugrp_d    = ugrp_q;
    term_fn_d = term_fn_q;
    preset_d  = preset_q;
    if (access && pwrite && !pslverr_q) begin
      if (preset_hit) begin
        preset_d[preset_idx] = pwdata[15:0];
      end else if (term_hit) begin
        term_fn_d[term_idx] = pwdata[7:0];
      end else begin
        case (paddr)
          `MSPS_OFF_OPMODE: opmode_d = pwdata[3:0];
          `MSPS_OFF_REMOTE: remote_d = pwdata[3:0];
          `MSPS_OFF_WRSEL:  wrsel_d  = pwdata[1:0];
          `MSPS_OFF_UGRP:   ugrp_d   = pwdata[15:0];
          default:          ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opmode_q <= `MSPS_MODE_RST;
      remote_q <= 4'h0;
      wrsel_q  <= `MSPS_WR_STOP;
      ugrp_q   <= 16'h0000;
      for (int i = 0; i < `MSPS_NUM_TERM; i++) begin
        term_fn_q[i] <= `MSPS_FN_NONE;
      end
      term_fn_q[0] <= `MSPS_FN_LOW;
      term_fn_q[1] <= `MSPS_FN_MID;
      term_fn_q[2] <= `MSPS_FN_HIGH;
      for (int i = 0; i < `MSPS_NUM_PRESET; i++) begin
        preset_q[i] <= `MSPS_NOT_SEL;
      end
      preset_q[`MSPS_SLOT_HIGH] <= `MSPS_HIGH_RST;
      preset_q[`MSPS_SLOT_MID]  <= `MSPS_MID_RST;
      preset_q[`MSPS_SLOT_LOW]  <= `MSPS_LOW_RST;
    end else begin
      opmode_q  <= opmode_d;
      remote_q  <= remote_d;
      wrsel_q   <= wrsel_d;
      ugrp_q    <= ugrp_d;
      term_fn_q <= term_fn_d;
      preset_q  <= preset_d;
    end
  end

  // ==========================================================================
  // APB answer
  // ==========================================================================
  always_comb begin
    rdata_d  = 32'h0000_0000;
    err_d    = 1'b0;
    pready_d = setup;
    if (preset_hit) begin
      rdata_d = {16'h0000, preset_q[preset_idx]};
      err_d   = pwrite && !preset_wr_ok;
    end else if (term_hit) begin
      rdata_d = {24'h00_0000, term_fn_q[term_idx]};
      err_d   = pwrite && !cfg_wr_ok;
    end else begin
      case (paddr)
        `MSPS_OFF_OPMODE: begin
          rdata_d = {28'h000_0000, opmode_q};
          err_d   = pwrite && !cfg_wr_ok;
        end
        `MSPS_OFF_REMOTE: begin
          rdata_d = {28'h000_0000, remote_q};
          err_d   = pwrite && !cfg_wr_ok;
        end
        `MSPS_OFF_WRSEL: begin
          rdata_d = {30'h0000_0000, wrsel_q};
          err_d   = pwrite && running;
        end
        `MSPS_OFF_UGRP: begin
          rdata_d = {16'h0000, ugrp_q};
          err_d   = pwrite && !cfg_wr_ok;
        end
        `MSPS_OFF_STATUS: begin
          rdata_d = {8'h00, dec_slot, dec_hit, 1'b0, src_q, freq_q};
          err_d   = pwrite;
        end
        `MSPS_OFF_INPUTS: begin
          rdata_d = {20'h0_0000, sel_ext, sel_high, sel_mid, sel_low, 1'b0, term_sync_q};
          err_d   = pwrite;
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
    if (!setup) begin
      rdata_d = prdata_q;
      err_d   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= rdata_d;
      pready_q  <= pready_d;
      pslverr_q <= err_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign freq_cmd     = freq_q;
  assign freq_src     = src_q;
  assign remote_accel = remote_sig_q[2];
  assign remote_decel = remote_sig_q[1];
  assign remote_clear = remote_sig_q[0];

endmodule // msps_top

// >>> bench/msps_props.sv
// Checker on the ports of the multi-speed preset selector top.
// Assumes a bind to msps_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "msps_params.svh"

module msps_props (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [`MSPS_NUM_TERM-1:0] term_in,
  input wire logic                      jog_active,
  input msps_pkg::msps_freq_t           jog_freq,
  input wire logic                      analog4_valid,
  input msps_pkg::msps_freq_t           analog4_freq,
  input msps_pkg::msps_freq_t           analog2_freq,
  input msps_pkg::msps_freq_t           freq_cmd,
  input msps_pkg::msps_src_e            freq_src,
  input wire logic                      remote_accel
);
  import msps_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // Bus handshake
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ======
  // Command selection
  a_jog_wins_all: assert property (jog_active |=> freq_src == MSPS_SRC_JOG && freq_cmd == $past(jog_freq))
    else $error("jog not selected");
  a_analog4_passes: assert property ($past(presetn) && freq_src == MSPS_SRC_ANALOG4 |-> freq_cmd == $past(analog4_freq))
    else $error("analog4 command altered");
  a_analog2_ranked: assert property ($past(presetn) && freq_src == MSPS_SRC_ANALOG2 |->
    freq_cmd == $past(analog2_freq) && !$past(analog4_valid))
    else $error("analog2 wrongly chosen");
  a_idle_no_preset: assert property ((!jog_active && term_in == '0) [*4] |=> freq_src != MSPS_SRC_PRESET)
    else $error("preset with no select on");
  a_remote_no_preset: assert property (remote_accel && $past(remote_accel) |-> freq_src != MSPS_SRC_PRESET)
    else $error("preset while remote on");
  a_preset_in_range: assert property (freq_src == MSPS_SRC_PRESET |-> freq_cmd <= `MSPS_FREQ_MAX)
    else $error("preset above range");
  c_preset: cover property (freq_src == MSPS_SRC_PRESET);
  c_refused: cover property (pslverr);
  c_remote: cover property (remote_accel);
  c_jog: cover property (freq_src == MSPS_SRC_JOG);
endmodule // msps_props

// >>> bench/msps_contacts.sv
// Model of the machine contact switches on the input terminals.
// Assumes the bench sets the wanted pattern; contacts settle off the clock grid.
`timescale 1ns/1ps
`include "msps_params.svh"

module msps_contacts (
  input  wire logic                      slow,
  input  wire logic [`MSPS_NUM_TERM-1:0] want,
  output logic      [`MSPS_NUM_TERM-1:0] term_in
);
  // ======
  // Contacts follow with a short or a long mechanical lag
  initial term_in = '0;
  always @(want) begin
    term_in <= #(slow ? 5.7 : 1.3) want;
  end
endmodule // msps_contacts

// >>> bench/tb_multi_speed_preset_selector.sv
// Self-checking bench for the multi-speed preset selector.
// Assumes the core files, the contact model and the checker are compiled first.
`timescale 1ns/1ps
`include "msps_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module tb_multi_speed_preset_selector;
  import msps_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, running, jog_active, analog4_valid, slow;
  logic        remote_accel, remote_decel, remote_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  want, term_in;
  msps_freq_t  jog_freq, analog4_freq, analog2_freq, freq_cmd;
  msps_src_e   freq_src;
  int          num_errors, check_count;
  localparam logic [3:0] SLOT7 [8] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h0, 4'h4, 4'h5, 4'h6};

  msps_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .term_in, .running, .jog_active, .jog_freq, .analog4_valid, .analog4_freq, .analog2_freq,
    .freq_cmd, .freq_src, .remote_accel, .remote_decel, .remote_clear);
  msps_contacts u_contacts (.slow, .want, .term_in);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ======
  // Bus and selection tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    `CHK(pslverr, e)
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    `CHK(rd, x)
  endtask

  task automatic pick(input logic [6:0] w, input msps_freq_t f, input msps_src_e s);
    want <= w;
    repeat (5) @(posedge pclk);
    `CHK(freq_cmd, f)
    `CHK(freq_src, s)
  endtask

  task conclude;
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude;
  end

  // ======
  // Test sequence
  initial begin
    {psel, penable, pwrite, running, jog_active, analog4_valid, slow} = '0;
    paddr = '0;
    pwdata = '0;
    want = '0;
    jog_freq = 16'h0032;
    analog4_freq = 16'h0456;
    analog2_freq = 16'h0123;
    num_errors = 0;
    check_count = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 15; i++) rd_chk(`MSPS_OFF_PRESET + 12'(4*i), i == 0 ? 32'h0000_01F4 : i == 1 ?
      32'h0000_012C : i == 2 ? 32'h0000_0064 : 32'h0000_270F);
    for (int i = 0; i < 7; i++) rd_chk(`MSPS_OFF_TERM + 12'(4*i), i < 3 ? 32'(i) : 32'h0000_00FF);
    pick(7'h00, analog2_freq, MSPS_SRC_ANALOG2);
    analog4_valid <= 1'b1;
    pick(7'h04, analog4_freq, MSPS_SRC_ANALOG4);
    apb(1'b1, `MSPS_OFF_OPMODE, 32'h0000_0003, 1'b0);
    pick(7'h04, 16'h01F4, MSPS_SRC_PRESET);
    apb(1'b1, `MSPS_OFF_OPMODE, 32'h0000_0004, 1'b0);
    pick(7'h02, 16'h012C, MSPS_SRC_PRESET);
    pick(7'h01, 16'h0064, MSPS_SRC_PRESET);
    pick(7'h06, 16'h012C, MSPS_SRC_PRESET);
    pick(7'h07, 16'h0064, MSPS_SRC_PRESET);
    apb(1'b1, `MSPS_OFF_OPMODE, 32'h0000_0005, 1'b0);
    pick(7'h01, analog4_freq, MSPS_SRC_ANALOG4);
    apb(1'b1, `MSPS_OFF_OPMODE, 32'h0000_0003, 1'b0);
    apb(1'b1, `MSPS_OFF_TERM + 12'h00C, 32'h0000_0008, 1'b0);
    apb(1'b1, `MSPS_OFF_TERM + 12'h010, 32'h0000_0002, 1'b0);
    running <= 1'b1;
    apb(1'b1, `MSPS_OFF_OPMODE, 32'h0000_0003, 1'b1);
    for (int i = 0; i < 15; i++) apb(1'b1, `MSPS_OFF_PRESET + 12'(4*i), 32'h0000_0100 + 32'(i), 1'b0);
    for (int c = 1; c < 16; c++) begin
      slow <= c[0];
      pick(7'(c), 16'h0100 + (c > 7 ? 16'(c - 1) : 16'(SLOT7[c])), MSPS_SRC_PRESET);
    end
    pick(7'h10, 16'h0100, MSPS_SRC_PRESET);
    rd_chk(`MSPS_OFF_INPUTS, 32'h0000_0410);
    apb(1'b1, `MSPS_OFF_PRESET + 12'h01C, 32'h0000_270F, 1'b0);
    pick(7'h08, 16'h0102, MSPS_SRC_PRESET);
    rd_chk(`MSPS_OFF_STATUS, 32'h0029_0102);
    apb(1'b1, `MSPS_OFF_PRESET, 32'h0000_270F, 1'b1);
    apb(1'b1, `MSPS_OFF_PRESET + 12'h00C, 32'h0000_0FA1, 1'b1);
    rd_chk(`MSPS_OFF_PRESET + 12'h00C, 32'h0000_0103);
    running <= 1'b0;
    apb(1'b1, `MSPS_OFF_UGRP, 32'h0000_0001, 1'b0);
    apb(1'b1, `MSPS_OFF_PRESET + 12'h010, 32'h0000_0200, 1'b1);
    apb(1'b1, `MSPS_OFF_PRESET, 32'h0000_0FA0, 1'b0);
    apb(1'b1, `MSPS_OFF_UGRP, 32'h0000_0000, 1'b0);
    pick(7'h04, 16'h0FA0, MSPS_SRC_PRESET);
    apb(1'b1, `MSPS_OFF_REMOTE, 32'h0000_0001, 1'b0);
    pick(7'h04, analog4_freq, MSPS_SRC_ANALOG4);
    `CHK(remote_accel, 1'b1)
    pick(7'h02, analog4_freq, MSPS_SRC_ANALOG4);
    `CHK(remote_decel, 1'b1)
    pick(7'h01, analog4_freq, MSPS_SRC_ANALOG4);
    `CHK(remote_clear, 1'b1)
    apb(1'b1, `MSPS_OFF_REMOTE, 32'h0000_0000, 1'b0);
    jog_active <= 1'b1;
    pick(7'h04, jog_freq, MSPS_SRC_JOG);
    jog_active <= 1'b0;
    apb(1'b0, 12'hFFC, 32'h0000_0000, 1'b1);
    conclude;
  end
endmodule // tb_multi_speed_preset_selector

bind msps_top msps_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .term_in, .jog_active,
  .jog_freq, .analog4_valid, .analog4_freq, .analog2_freq, .freq_cmd, .freq_src, .remote_accel);
